/* File: fpc_consts.svh */
// constants of the front panel encoder control block
`ifndef FPC_CONSTS_SVH
`define FPC_CONSTS_SVH

// ==========================================================
// timing
`define FPC_CLK_PERIOD_NS  10
`define FPC_LONG_PUSH_MS   1000

// ==========================================================
// channels and selectable entries
`define FPC_NUM_CH         22
`define FPC_NV_LAST_ADDR   5'h16
`define FPC_ENTRY_LAST     5'h13
`define FPC_ENTRY_LINE     5'h04
`define FPC_ENTRY_PH       5'h0A
`define FPC_ENTRY_SP       5'h0B
`define FPC_ENTRY_OPT      5'h0C
`define FPC_CH_SP          5'h0C

// ==========================================================
// level codes
`define FPC_MIC_MAX_CODE   8'h38
`define FPC_INST_MAX_CODE  8'h24
`define FPC_OUT_MAX_CODE   8'h41

// ==========================================================
// stored configuration word layout
`define FPC_CFG_RATE_LSB   0
`define FPC_CFG_RATE_MSB   3
`define FPC_CFG_MASTER     4
`define FPC_CFG_CHAN_LSB   5
`define FPC_CFG_CHAN_MSB   7
`define FPC_CFG_DIG_LSB    8
`define FPC_CFG_DIG_MSB    9
`define FPC_CFG_REMOTE     10
`define FPC_CFG_LINK       11

// ==========================================================
// indicator thresholds in dBFS
`define FPC_SIG_DBFS       8'hBF
`define FPC_OVL_DBFS       8'hFE

// ==========================================================
// note numbers and velocity
`define FPC_NOTE_UP        7'h10
`define FPC_NOTE_DOWN      7'h11
`define FPC_NOTE_SHORT     7'h20
`define FPC_NOTE_LONG      7'h21
`define FPC_NOTE_VEL       7'h7F

`endif

/* File: fpc_pkg.sv */
// types of the front panel encoder control block
package fpc_pkg;

    typedef enum logic [1:0] {
        ST_LOAD = 2'h1,
        ST_RUN  = 2'h2
    } fpc_state_type;

    typedef enum logic [2:0] {
        GRP_INPUT,
        GRP_LINE,
        headphone_pair_code,
        digital_stereo_out_code,
        GRP_OPTICAL
    } fpc_group_type;

    typedef struct packed {
        logic [3:0] sample_rate;
        logic       clock_master;
        logic [2:0] chan_cfg;
        logic [1:0] digital_cfg;
        logic       remote_en;
    } fpc_cfg_type;

    typedef struct packed {
        logic          show_link;
        logic          link_on;
        fpc_group_type group;
        logic [3:0]    number;
        logic          show_value;
        logic [7:0]    value;
        logic          dot;
    } fpc_disp_type;

    typedef struct packed {
        logic [6:0] num;
        logic [6:0] vel;
    } fpc_note_type;

endpackage

/* File: fpc_level_ind.sv */
// signal present and overload indicator for one input pair
`timescale 1ns/1ns
`default_nettype none
`include "fpc_consts.svh"
module fpc_level_ind (
    input  wire logic             CLK_SYS,
    input  wire logic             RST,
    input  wire logic signed [7:0] LEVEL,
    output logic                  SIG_LED,
    output logic                  OVL_LED
);
    import fpc_pkg::*;

    localparam logic signed [7:0] SIG_TH = `FPC_SIG_DBFS;
    localparam logic signed [7:0] OVL_TH = `FPC_OVL_DBFS;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            SIG_LED <= 1'b0;
            OVL_LED <= 1'b0;
        end else begin
            SIG_LED <= (LEVEL >= SIG_TH);
            OVL_LED <= (LEVEL >= OVL_TH);
        end
    end

    // ==========================================================
    // checks
    property p_ovl_has_sig;
        @(posedge CLK_SYS) disable iff (RST) OVL_LED |-> SIG_LED;
    endproperty
    a_ovl_has_sig: assert property (p_ovl_has_sig) else $error("overload without signal");

    property p_sig_level;
        @(posedge CLK_SYS) disable iff (RST) (LEVEL < SIG_TH) |=> !SIG_LED;
    endproperty
    a_sig_level: assert property (p_sig_level) else $error("signal led below threshold");

endmodule
`default_nettype wire

/* File: fpc_front_panel.sv */
// front panel encoder control: modes, levels, link, config load, notes
`timescale 1ns/1ns
`default_nettype none
`include "fpc_consts.svh"
module fpc_front_panel #(
    parameter int LONG_PUSH_CYC = `FPC_LONG_PUSH_MS * 1000000 / `FPC_CLK_PERIOD_NS
) (
    input  wire logic                CLK_SYS,
    input  wire logic                RST,
    input  wire logic                ENC_A,
    input  wire logic                ENC_B,
    input  wire logic                ENC_PUSH,
    input  wire logic                STANDALONE,
    output logic                     NV_RD,
    output logic [4:0]               NV_ADDR,
    input  wire logic [15:0]         NV_RDATA,
    input  wire logic                NV_ACK,
    output logic                     CFG_VALID,
    output fpc_pkg::fpc_cfg_type     CFG,
    output logic                     LVL_WE,
    output logic [4:0]               LVL_CH,
    output logic [7:0]               LVL_VAL,
    output fpc_pkg::fpc_disp_type    DISP,
    output logic                     LED_LEVEL_MODE,
    output logic                     NOTE_VALID,
    output fpc_pkg::fpc_note_type    NOTE,
    input  wire logic                NOTE_READY,
    input  wire logic signed [7:0]   IN_LEVEL_12,
    input  wire logic signed [7:0]   IN_LEVEL_34,
    output logic [1:0]               SIG_LED,
    output logic [1:0]               OVL_LED
);
    import fpc_pkg::*;

    fpc_state_type state_reg;
    logic [2:0]    sync1_reg;
    logic [2:0]    sync2_reg;
    logic          a_d_reg;
    logic          push_d_reg;
    logic [31:0]   push_cnt_reg;
    logic [4:0]    nv_addr_reg;
    logic          mode_level_reg;
    logic          link_reg;
    logic [4:0]    entry_reg;
    logic [7:0]    lvl_reg [0:`FPC_NUM_CH-1];
    logic          pend_reg;
    logic          run;
    logic          up_evt;
    logic          dn_evt;
    logic          short_evt;
    logic          long_evt;
    logic          load_ack;
    logic          adjust;
    logic          pair;
    logic [4:0]    sel_ch;
    logic [7:0]    cur_code;
    logic [7:0]    max_code;
    logic [7:0]    new_code;

    // ==========================================================
    // helpers
    function automatic logic [4:0] entry_to_ch(input logic [4:0] e);
        if (e <= `FPC_ENTRY_PH)
            return e;
        else if (e == `FPC_ENTRY_SP)
            return `FPC_CH_SP;
        else
            return e + 5'h02;
    endfunction

    function automatic logic [7:0] ch_max(input logic [4:0] ch);
        if (ch < 5'h02)
            return `FPC_MIC_MAX_CODE;
        else if (ch < 5'h04)
            return `FPC_INST_MAX_CODE;
        else
            return `FPC_OUT_MAX_CODE;
    endfunction

    function automatic logic [4:0] step_up(input logic [4:0] e, input logic lk);
        if (!lk || e == `FPC_ENTRY_PH || e == `FPC_ENTRY_SP)
            return (e == `FPC_ENTRY_LAST) ? e : e + 5'h01;
        else
            return (e >= `FPC_ENTRY_LAST - 5'h01) ? e : e + 5'h02;
    endfunction

    function automatic logic [4:0] step_dn(input logic [4:0] e, input logic lk);
        if (!lk || e == `FPC_ENTRY_SP || e == `FPC_ENTRY_OPT)
            return (e == 5'h00) ? e : e - 5'h01;
        else
            return (e < 5'h02) ? 5'h00 : e - 5'h02;
    endfunction

    // ==========================================================
    // pin synchronisers and event decode
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            a_d_reg   <= 1'b0;
            push_d_reg <= 1'b0;
        end else begin
            sync1_reg <= {ENC_PUSH, ENC_B, ENC_A};
            sync2_reg <= sync1_reg;
            a_d_reg   <= sync2_reg[0];
            push_d_reg <= sync2_reg[2];
        end
    end

    assign run    = (state_reg == ST_RUN);
    assign up_evt = run && sync2_reg[0] && !a_d_reg && !sync2_reg[1];
    assign dn_evt = run && sync2_reg[0] && !a_d_reg && sync2_reg[1];

    // push length judged on release
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            push_cnt_reg <= 32'h0000_0000;
        end else if (!sync2_reg[2]) begin
            push_cnt_reg <= 32'h0000_0000;
        end else if (push_cnt_reg < 32'(LONG_PUSH_CYC)) begin
            push_cnt_reg <= push_cnt_reg + 32'h0000_0001;
        end
    end

    assign short_evt = run && push_d_reg && !sync2_reg[2]
                       && (push_cnt_reg < 32'(LONG_PUSH_CYC));
    assign long_evt  = run && push_d_reg && !sync2_reg[2]
                       && (push_cnt_reg >= 32'(LONG_PUSH_CYC));

    // ==========================================================
    // power-on load of stored configuration
    assign NV_RD    = (state_reg == ST_LOAD);
    assign NV_ADDR  = nv_addr_reg;
    assign load_ack = NV_RD && NV_ACK;
    assign CFG_VALID = run;

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            state_reg   <= ST_LOAD;
            nv_addr_reg <= 5'h00;
            CFG         <= '0;
        end else begin
            case (state_reg)
                ST_LOAD: begin
                    if (load_ack) begin
                        if (nv_addr_reg == 5'h00) begin
                            CFG.sample_rate  <= NV_RDATA[`FPC_CFG_RATE_MSB:`FPC_CFG_RATE_LSB];
                            CFG.clock_master <= NV_RDATA[`FPC_CFG_MASTER];
                            CFG.chan_cfg     <= NV_RDATA[`FPC_CFG_CHAN_MSB:`FPC_CFG_CHAN_LSB];
                            CFG.digital_cfg  <= NV_RDATA[`FPC_CFG_DIG_MSB:`FPC_CFG_DIG_LSB];
                            CFG.remote_en    <= NV_RDATA[`FPC_CFG_REMOTE];
                        end
                        if (nv_addr_reg == `FPC_NV_LAST_ADDR)
                            state_reg <= ST_RUN;
                        nv_addr_reg <= nv_addr_reg + 5'h01;
                    end
                end
                ST_RUN: begin
                    state_reg <= ST_RUN;
                end
                default: begin
                    state_reg <= ST_LOAD;
                end
            endcase
        end
    end

    // ==========================================================
    // mode, link and channel selection
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            mode_level_reg <= 1'b0;
            link_reg       <= 1'b0;
            entry_reg      <= 5'h00;
        end else if (load_ack && nv_addr_reg == 5'h00) begin
            link_reg <= NV_RDATA[`FPC_CFG_LINK];
        end else if (short_evt) begin
            mode_level_reg <= !mode_level_reg;
        end else if (long_evt) begin
            link_reg <= !link_reg;
            if (!link_reg && entry_reg != `FPC_ENTRY_SP)
                entry_reg <= entry_reg & 5'h1E;
        end else if (!mode_level_reg && up_evt) begin
            entry_reg <= step_up(entry_reg, link_reg);
        end else if (!mode_level_reg && dn_evt) begin
            entry_reg <= step_dn(entry_reg, link_reg);
        end
    end

    assign LED_LEVEL_MODE = mode_level_reg;

    // ==========================================================
    // level store and writes to the mixing path
    assign sel_ch   = entry_to_ch(entry_reg);
    assign cur_code = lvl_reg[sel_ch];
    assign max_code = ch_max(sel_ch);
    assign adjust   = mode_level_reg && (up_evt || dn_evt);
    assign pair     = link_reg || entry_reg == `FPC_ENTRY_PH || entry_reg == `FPC_ENTRY_SP;

    always_comb begin
        new_code = cur_code;
        if (up_evt && cur_code < max_code)
            new_code = cur_code + 8'h01;
        else if (dn_evt && cur_code != 8'h00)
            new_code = cur_code - 8'h01;
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < `FPC_NUM_CH; i++)
                lvl_reg[i] <= 8'h00;
            LVL_WE   <= 1'b0;
            LVL_CH   <= 5'h00;
            LVL_VAL  <= 8'h00;
            pend_reg <= 1'b0;
        end else begin
            LVL_WE   <= 1'b0;
            pend_reg <= 1'b0;
            if (load_ack && nv_addr_reg != 5'h00) begin
                lvl_reg[nv_addr_reg - 5'h01] <= (NV_RDATA[7:0] > ch_max(nv_addr_reg - 5'h01))
                    ? ch_max(nv_addr_reg - 5'h01) : NV_RDATA[7:0];
                LVL_WE  <= 1'b1;
                LVL_CH  <= nv_addr_reg - 5'h01;
                LVL_VAL <= (NV_RDATA[7:0] > ch_max(nv_addr_reg - 5'h01))
                    ? ch_max(nv_addr_reg - 5'h01) : NV_RDATA[7:0];
            end else if (pend_reg) begin
                LVL_WE <= 1'b1;
                LVL_CH <= LVL_CH + 5'h01;
            end else if (adjust) begin
                lvl_reg[sel_ch] <= new_code;
                if (pair)
                    lvl_reg[sel_ch + 5'h01] <= new_code;
                LVL_WE   <= 1'b1;
                LVL_CH   <= sel_ch;
                LVL_VAL  <= new_code;
                pend_reg <= pair;
            end
        end
    end

    // ==========================================================
    // display
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            DISP <= '0;
        end else begin
            if (long_evt)
                DISP.show_link <= 1'b1;
            else if (short_evt || up_evt || dn_evt)
                DISP.show_link <= 1'b0;
            DISP.link_on    <= link_reg;
            DISP.show_value <= mode_level_reg;
            DISP.value      <= cur_code;
            DISP.dot        <= (sel_ch == 5'h02 || sel_ch == 5'h03) && cur_code[0];
            if (entry_reg < `FPC_ENTRY_LINE) begin
                DISP.group  <= GRP_INPUT;
                DISP.number <= 4'(entry_reg + 5'h01);
            end else if (entry_reg < `FPC_ENTRY_PH) begin
                DISP.group  <= GRP_LINE;
                DISP.number <= 4'(entry_reg - 5'h03);
            end else if (entry_reg == `FPC_ENTRY_PH) begin
                DISP.group  <= headphone_pair_code;
                DISP.number <= 4'h0;
            end else if (entry_reg == `FPC_ENTRY_SP) begin
                DISP.group  <= digital_stereo_out_code;
                DISP.number <= 4'h0;
            end else begin
                DISP.group  <= GRP_OPTICAL;
                DISP.number <= 4'(entry_reg - 5'h0B);
            end
        end
    end

    // ==========================================================
    // remote control notes, new event wins over acceptance
    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            NOTE_VALID <= 1'b0;
            NOTE       <= '0;
        end else if (CFG.remote_en && STANDALONE
                     && (up_evt || dn_evt || short_evt || long_evt)) begin
            NOTE_VALID <= 1'b1;
            NOTE.vel   <= `FPC_NOTE_VEL;
            NOTE.num   <= up_evt ? `FPC_NOTE_UP : dn_evt ? `FPC_NOTE_DOWN
                        : short_evt ? `FPC_NOTE_SHORT : `FPC_NOTE_LONG;
        end else if (NOTE_READY) begin
            NOTE_VALID <= 1'b0;
        end
    end

    // ==========================================================
    // input pair indicators
    fpc_level_ind u_ind_12 (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .LEVEL   (IN_LEVEL_12),
        .SIG_LED (SIG_LED[0]),
        .OVL_LED (OVL_LED[0])
    );

    fpc_level_ind u_ind_34 (
        .CLK_SYS (CLK_SYS),
        .RST     (RST),
        .LEVEL   (IN_LEVEL_34),
        .SIG_LED (SIG_LED[1]),
        .OVL_LED (OVL_LED[1])
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    property p_short_mode;
        short_evt |=> (mode_level_reg != $past(mode_level_reg)) && $stable(link_reg);
    endproperty
    a_short_mode: assert property (p_short_mode) else $error("short push did not toggle mode");

    property p_long_link;
        long_evt |=> (link_reg != $past(link_reg)) && $stable(mode_level_reg) ##1 DISP.show_link;
    endproperty
    a_long_link: assert property (p_long_link) else $error("long push did not toggle link");

    property p_link_odd;
        link_reg && run && !long_evt |=> entry_reg[0] == 1'b0 || entry_reg == `FPC_ENTRY_SP;
    endproperty
    a_link_odd: assert property (p_link_odd) else $error("right channel selectable while linked");

    property p_pair_write;
        pend_reg |-> LVL_WE ##1 LVL_WE && LVL_CH == $past(LVL_CH) + 5'h01 && $stable(LVL_VAL);
    endproperty
    a_pair_write: assert property (p_pair_write) else $error("partner channel not written");

    property p_clamp;
        LVL_WE |-> LVL_VAL <= ch_max(LVL_CH);
    endproperty
    a_clamp: assert property (p_clamp) else $error("level code beyond range");

    property p_load_first;
        $past(RST) |-> NV_RD && NV_ADDR == 5'h00 && !CFG_VALID;
    endproperty
    a_load_first: assert property (p_load_first) else $error("no load after reset");

    property p_note_gate;
        $rose(NOTE_VALID) |-> $past(CFG.remote_en) && $past(STANDALONE);
    endproperty
    a_note_gate: assert property (p_note_gate) else $error("note sent while remote off");

    property p_dot;
        DISP.dot |-> DISP.value[0] && (DISP.group == GRP_INPUT) && DISP.number >= 4'h3;
    endproperty
    a_dot: assert property (p_dot) else $error("dot shown without half step");

    property p_no_wrap;
        adjust && up_evt && cur_code == max_code |=> LVL_VAL == $past(max_code);
    endproperty
    a_no_wrap: assert property (p_no_wrap) else $error("level wrapped at top");

    c_long_push:  cover property (long_evt);
    c_pair_write: cover property (pend_reg ##1 LVL_WE);
    c_note_sent:  cover property (NOTE_VALID && NOTE_READY);

endmodule
`default_nettype wire

/* File: fpc_knob_model.sv */
// knob, push button, settings memory and note receiver model
`timescale 1ns/1ns
`default_nettype none
module fpc_knob_model (
    input  wire logic        CLK_SYS,
    input  wire logic        NV_RD,
    input  wire logic [4:0]  NV_ADDR,
    input  wire logic        NOTE_VALID,
    output logic             ENC_A,
    output logic             ENC_B,
    output logic             ENC_PUSH,
    output logic [15:0]      NV_RDATA,
    output logic             NV_ACK,
    output logic             NOTE_READY
);
    logic [15:0] mem [0:22];

    // ==========================================================
    // stored words: config, then channel codes
    initial begin
        ENC_A = 1'b0;
        ENC_B = 1'b0;
        ENC_PUSH = 1'b0;
        NV_ACK = 1'b0;
        NOTE_READY = 1'b0;
        for (int i = 1; i < 23; i++) begin
            mem[i] = 16'h0010;
        end
        mem[0] = 16'h06B5;
        mem[1] = 16'h0037;
        mem[2] = 16'h00FF;
        mem[3] = 16'h0004;
        mem[5] = 16'h0030;
        mem[6] = 16'h0030;
    end

    // ==========================================================
    // slow answers: every other cycle
    always @(negedge CLK_SYS) begin
        NV_ACK <= NV_RD && !NV_ACK;
        NOTE_READY <= NOTE_VALID && !NOTE_READY;
    end
    assign NV_RDATA = NV_RD ? mem[NV_ADDR] : 16'hA5A5;

    // ==========================================================
    // knob actions
    task automatic turn(input logic up);
        @(negedge CLK_SYS) ENC_B = !up;
        repeat (4) @(negedge CLK_SYS);
        ENC_A = 1'b1;
        repeat (4) @(negedge CLK_SYS);
        ENC_A = 1'b0;
        repeat (4) @(negedge CLK_SYS);
    endtask

    task automatic press(input int cyc);
        @(negedge CLK_SYS) ENC_PUSH = 1'b1;
        repeat (cyc) @(negedge CLK_SYS);
        ENC_PUSH = 1'b0;
        repeat (6) @(negedge CLK_SYS);
    endtask
endmodule
`default_nettype wire

/* File: fpc_front_panel_tb.sv */
// self-checking testbench of the front panel encoder control
`timescale 1ns/1ns
`default_nettype none
module fpc_front_panel_tb;
    import fpc_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic              standalone = 1'b1;
    logic signed [7:0] in_level_12 = 8'h80;
    logic signed [7:0] in_level_34 = 8'h80;
    logic              enc_a;
    logic              enc_b;
    logic              enc_push;
    logic              nv_rd;
    logic              nv_ack;
    logic              cfg_valid;
    logic              lvl_we;
    logic              led_level_mode;
    logic              note_valid;
    logic              note_ready;
    logic [4:0]        nv_addr;
    logic [4:0]        lvl_ch;
    logic [15:0]       nv_rdata;
    logic [7:0]        lvl_val;
    logic [1:0]        sig_led;
    logic [1:0]        ovl_led;
    fpc_cfg_type       cfg;
    fpc_disp_type      disp;
    fpc_note_type      note;
    int                err_count = 0;
    int                n_tests = 0;
    logic [7:0]        lv [0:21];
    logic [6:0]        last_note = 7'h00;
    int                note_cnt = 0;

    always #5 clk_sys = !clk_sys;

    fpc_front_panel #(
        .LONG_PUSH_CYC  (20)
    ) dut (
        .CLK_SYS        (clk_sys),
        .RST            (rst),
        .ENC_A          (enc_a),
        .ENC_B          (enc_b),
        .ENC_PUSH       (enc_push),
        .STANDALONE     (standalone),
        .NV_RD          (nv_rd),
        .NV_ADDR        (nv_addr),
        .NV_RDATA       (nv_rdata),
        .NV_ACK         (nv_ack),
        .CFG_VALID      (cfg_valid),
        .CFG            (cfg),
        .LVL_WE         (lvl_we),
        .LVL_CH         (lvl_ch),
        .LVL_VAL        (lvl_val),
        .DISP           (disp),
        .LED_LEVEL_MODE (led_level_mode),
        .NOTE_VALID     (note_valid),
        .NOTE           (note),
        .NOTE_READY     (note_ready),
        .IN_LEVEL_12    (in_level_12),
        .IN_LEVEL_34    (in_level_34),
        .SIG_LED        (sig_led),
        .OVL_LED        (ovl_led)
    );

    fpc_knob_model knob (
        .CLK_SYS        (clk_sys),
        .NV_RD          (nv_rd),
        .NV_ADDR        (nv_addr),
        .NOTE_VALID     (note_valid),
        .ENC_A          (enc_a),
        .ENC_B          (enc_b),
        .ENC_PUSH       (enc_push),
        .NV_RDATA       (nv_rdata),
        .NV_ACK         (nv_ack),
        .NOTE_READY     (note_ready)
    );

    // ==========================================================
    // capture of level writes and accepted notes
    always @(posedge clk_sys) begin
        if (lvl_we === 1'b1) begin
            lv[lvl_ch] <= lvl_val;
        end
        if (note_valid === 1'b1 && note_ready === 1'b1) begin
            last_note <= note.num;
            note_cnt  <= note_cnt + 1;
        end
    end

    // ==========================================================
    // helpers
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_load;
        for (int i = 0; i < 200 && cfg_valid !== 1'b1; i++) begin
            @(negedge clk_sys);
        end
        chk("cfg_valid", 8'h01, 8'(cfg_valid));
        chk("sample_rate", 8'h05, 8'(cfg.sample_rate));
        chk("remote_en", 8'h01, 8'(cfg.remote_en));
        chk("clock_master", 8'h01, 8'(cfg.clock_master));
        chk("chan_cfg", 8'h05, 8'(cfg.chan_cfg));
        chk("digital_cfg", 8'h02, 8'(cfg.digital_cfg));
        chk("ch0 code", 8'h37, lv[0]);
        chk("ch1 clamp", 8'h38, lv[1]);
        chk("mode led", 8'h00, 8'(led_level_mode));
        $display("test load done");
    endtask

    task automatic t_mic;
        knob.press(5);
        chk("mode led", 8'h01, 8'(led_level_mode));
        chk("short note", 8'h20, 8'(last_note));
        chk("note vel", 8'h7F, 8'(note.vel));
        chk("show value", 8'h01, 8'(disp.show_value));
        knob.turn(1'b1);
        knob.turn(1'b1);
        chk("ch0 clamp", 8'h38, lv[0]);
        chk("shown gain", 8'h38, disp.value);
        chk("up note", 8'h10, 8'(last_note));
        $display("test mic done");
    endtask

    task automatic t_inst;
        knob.press(5);
        knob.turn(1'b1);
        knob.turn(1'b1);
        chk("entry number", 8'h03, 8'(disp.number));
        knob.press(5);
        knob.turn(1'b1);
        chk("ch2 code", 8'h05, lv[2]);
        chk("half dot", 8'h01, 8'(disp.dot));
        knob.turn(1'b0);
        chk("ch2 code", 8'h04, lv[2]);
        chk("whole dot", 8'h00, 8'(disp.dot));
        chk("down note", 8'h11, 8'(last_note));
        $display("test inst done");
    endtask

    task automatic t_link;
        int seen;
        knob.press(5);
        knob.press(40);
        chk("show link", 8'h01, 8'(disp.show_link));
        chk("link on", 8'h01, 8'(disp.link_on));
        chk("mode kept", 8'h00, 8'(led_level_mode));
        chk("long note", 8'h21, 8'(last_note));
        knob.turn(1'b1);
        chk("group", 8'(GRP_LINE), 8'(disp.group));
        chk("line number", 8'h01, 8'(disp.number));
        knob.press(5);
        knob.turn(1'b0);
        chk("ch4 code", 8'h2F, lv[4]);
        chk("ch5 code", 8'h2F, lv[5]);
        standalone = 1'b0;
        seen = note_cnt;
        knob.turn(1'b1);
        chk("no note", 8'(seen), 8'(note_cnt));
        $display("test link done");
    endtask

    task automatic t_ind;
        in_level_12 = -8'sd66;
        settle(3);
        chk("sig below", 8'h00, 8'(sig_led[0]));
        in_level_12 = -8'sd65;
        in_level_34 = -8'sd3;
        settle(3);
        chk("sig at", 8'h01, 8'(sig_led[0]));
        chk("ovl below", 8'h00, 8'(ovl_led[1]));
        in_level_34 = -8'sd2;
        settle(3);
        chk("ovl at", 8'h03, {6'h00, ovl_led[1], sig_led[1]});
        $display("test indicators done");
    endtask

    // ==========================================================
    // main sequence and watchdog
    initial begin
        settle(3);
        rst = 1'b0;
        t_load();
        t_mic();
        t_inst();
        t_link();
        t_ind();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
